// >>> logic/smq_pkg.sv
// Shared constants and types for the status enable and message queue block.
//
// Function
// - Standard mask accepts 0..255, query returns it.
// - Operation mask accepts 0..65535, query returns it.
// - Measurement and questionable masks accept 0..65535 likewise.
// - Reset and preset zero masks; clear-status keeps.
// - Writing zero clears that whole mask.
// - Every query response goes into output queue.
// - Output queue data sets message-available flag.
// - Reading output queue removes that message.
// - Empty output queue clears message-available flag.
// - Admitted error message sets error-available flag.
// - Empty error queue clears error-available flag.
// - Error queue holds at most ten entries.
// - Error read returns oldest entry, then removes it.
// - Filling queue stores overflow code 350 last.
// - Empty error queue read returns code 0.
// - Entry codes are signed; sign tells origin.
// - Reset admits error messages, excludes status messages.
// - Enable lists exact set; disable removes listed.
// - List holds codes, ranges; empty enable blocks all.
// - Reset, clear-status, queue-clear empty queue; preset keeps.
// - Clear-status and preset keep enabled code set.
// - Event AND mask forms register summary bit.
// - Message-available flag sits at status bit 4.
package smq_pkg;

   localparam int ERR_DEPTH  = 10;
   localparam int OUT_DEPTH  = 16;
   localparam int LIST_DEPTH = 8;
   localparam int WORD_W     = 32;
   localparam int CODE_W     = 16;
   localparam int TEXT_W     = 8;
   localparam int ERR_W      = CODE_W + TEXT_W;

   localparam logic [31:0] STD_MAX   = 32'h0000_00FF;
   localparam logic [31:0] REG16_MAX = 32'h0000_FFFF;

   localparam logic [7:0]  STD_MASK_RST = 8'h00;
   localparam logic [15:0] REG16_RST    = 16'h0000;
   localparam logic        BASE_ERR_RST = 1'b1;
   localparam logic        BASE_STA_RST = 1'b0;

   localparam logic signed [15:0] CODE_OVF   = 16'sh015E;
   localparam logic signed [15:0] CODE_NOERR = 16'sh0000;
   localparam logic [7:0]         TEXT_OVF   = 8'h01;
   localparam logic [7:0]         TEXT_NOERR = 8'h00;

   localparam int STB_MAV_BIT = 4;
   localparam int STB_EAV_BIT = 2;

   localparam int SUM_STD  = 0;
   localparam int SUM_OPER = 1;
   localparam int SUM_MEAS = 2;
   localparam int SUM_QUES = 3;

   typedef enum logic [3:0] {
      CMD_WR_STD     = 4'h0,
      CMD_RD_STD     = 4'h1,
      CMD_WR_OPER    = 4'h2,
      CMD_RD_OPER    = 4'h3,
      CMD_WR_MEAS    = 4'h4,
      CMD_RD_MEAS    = 4'h5,
      CMD_WR_QUES    = 4'h6,
      CMD_RD_QUES    = 4'h7,
      CMD_QUE_READ   = 4'h8,
      CMD_QUE_CLEAR  = 4'h9,
      CMD_CLS        = 4'hA,
      CMD_PRESET     = 4'hB,
      CMD_QEN_START  = 4'hC,
      CMD_QDIS_START = 4'hD,
      CMD_QLIST_ITEM = 4'hE
   } smq_cmd_t;

   typedef struct packed {
      logic               valid;
      logic               allow;
      logic signed [15:0] lo;
      logic signed [15:0] hi;
   } smq_range_t;

endpackage : smq_pkg

// >>> logic/smq_fifo_if.sv
// Push and pop carrier between the queue owner and a FIFO.
`timescale 1ns/100ps
`default_nettype none
interface smq_fifo_if #(parameter int W = 32, parameter int D = 8);
   localparam int CW = $clog2(D + 1);
   logic          push;
   logic [W-1:0]  wdata;
   logic          pop;
   logic          clear;
   logic [W-1:0]  rdata;
   logic [CW-1:0] count;
   logic          full;
   logic          empty;
   modport fifo (input push, wdata, pop, clear, output rdata, count, full, empty);
   modport user (output push, wdata, pop, clear, input rdata, count, full, empty);
endinterface : smq_fifo_if
`default_nettype wire

// >>> logic/smq_fifo.sv
// First-in first-out store with synchronous clear, used for both queues.
`timescale 1ns/100ps
`default_nettype none
module smq_fifo #(
   parameter int W = 32,
   parameter int D = 8
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   smq_fifo_if.fifo port
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0]       rd;
      logic [PW-1:0]       wr;
      logic [CW-1:0]       cnt;
   } smq_fifo_st_t;

   smq_fifo_st_t q;
   smq_fifo_st_t d;
   logic         do_push;
   logic         do_pop;

   function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
      return (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : step

   always_comb begin
      do_pop  = port.pop && (q.cnt != '0) && !port.clear;
      do_push = port.push && (port.clear || (q.cnt != CW'(D)));
      d = q;
      if (port.clear) begin
         d.rd  = '0;
         d.wr  = '0;
         d.cnt = '0;
      end else if (do_pop) begin
         d.rd  = step(q.rd);
         d.cnt = CW'(q.cnt - 1'b1);
      end
      if (do_push) begin
         d.mem[d.wr] = port.wdata;
         d.wr        = step(d.wr);
         d.cnt       = CW'(d.cnt + 1'b1);
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign port.rdata = q.mem[q.rd];
   assign port.count = q.cnt;
   assign port.full  = (q.cnt == CW'(D));
   assign port.empty = (q.cnt == '0);

   property p_fifo_bound;
      @(posedge i_core_clk) disable iff (i_rst) q.cnt <= CW'(D);
   endproperty
   a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO count above depth.");

endmodule : smq_fifo
`default_nettype wire

// >>> logic/smq_top.sv
// Enable masks, output queue and filtered error queue of the status block.
`timescale 1ns/100ps
`default_nettype none
module smq_top #(
   parameter int ERR_DEPTH  = smq_pkg::ERR_DEPTH,
   parameter int OUT_DEPTH  = smq_pkg::OUT_DEPTH,
   parameter int LIST_DEPTH = smq_pkg::LIST_DEPTH
) (
   input  wire logic               i_core_clk,
   input  wire logic               i_rst,
   input  wire logic               i_cmd_valid,
   input  wire smq_pkg::smq_cmd_t  i_cmd_op,
   input  wire logic [31:0]        i_cmd_data,
   output logic                    o_cmd_ready,
   input  wire logic               i_talk_rd,
   output logic                    o_talk_valid,
   output logic [31:0]             o_talk_data,
   input  wire logic               i_msg_valid,
   input  wire logic signed [15:0] i_msg_code,
   input  wire logic [7:0]         i_msg_text,
   input  wire logic               i_msg_is_status,
   input  wire logic [7:0]         i_std_event,
   input  wire logic [15:0]        i_oper_event,
   input  wire logic [15:0]        i_meas_event,
   input  wire logic [15:0]        i_ques_event,
   output logic [3:0]              o_event_summary,
   output logic [7:0]              o_status_byte
);
   import smq_pkg::*;

   localparam int ECW = $clog2(ERR_DEPTH + 1);
   localparam int LCW = $clog2(LIST_DEPTH + 1);

   typedef struct packed {
      logic [7:0]                  std_mask;
      logic [15:0]                 oper_mask;
      logic [15:0]                 meas_mask;
      logic [15:0]                 ques_mask;
      logic                        base_err;
      logic                        base_sta;
      logic                        list_allow;
      smq_range_t [LIST_DEPTH-1:0] list;
      logic [LCW-1:0]              list_cnt;
      logic [3:0]                  summ;
   } smq_state_t;

   smq_state_t         q;
   smq_state_t         d;
   logic               is_query;
   logic               accept;
   logic [ECW-1:0]     err_cnt_eff;
   logic signed [15:0] code_a;
   logic signed [15:0] code_b;

   smq_fifo_if #(.W(WORD_W), .D(OUT_DEPTH)) oq ();
   smq_fifo_if #(.W(ERR_W),  .D(ERR_DEPTH)) eq ();

   smq_fifo #(.W(WORD_W), .D(OUT_DEPTH)) u_out_queue (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .port       (oq.fifo)
   );

   smq_fifo #(.W(ERR_W), .D(ERR_DEPTH)) u_err_queue (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .port       (eq.fifo)
   );

   // Last matching list entry decides; otherwise the class default applies.
   function automatic logic admits(input smq_state_t s, input logic signed [15:0] code,
                                   input logic is_sta);
      logic r;
      r = is_sta ? s.base_sta : s.base_err;
      for (int i = 0; i < LIST_DEPTH; i++) begin
         if (s.list[i].valid && (code >= s.list[i].lo) && (code <= s.list[i].hi)) begin
            r = s.list[i].allow;
         end
      end
      return r;
   endfunction : admits

   always_comb begin
      is_query    = (i_cmd_op inside {CMD_RD_STD, CMD_RD_OPER, CMD_RD_MEAS, CMD_RD_QUES,
                                      CMD_QUE_READ});
      o_cmd_ready = !(is_query && oq.full);
      accept      = i_cmd_valid && o_cmd_ready;
   end

   always_comb begin
      d           = q;
      code_a      = signed'(i_cmd_data[15:0]);
      code_b      = signed'(i_cmd_data[31:16]);
      oq.push     = 1'b0;
      oq.wdata    = '0;
      oq.pop      = i_talk_rd && !oq.empty;
      oq.clear    = 1'b0;
      eq.push     = 1'b0;
      eq.wdata    = '0;
      eq.pop      = 1'b0;
      eq.clear    = 1'b0;
      d.summ[SUM_STD]  = |(i_std_event & q.std_mask);
      d.summ[SUM_OPER] = |(i_oper_event & q.oper_mask);
      d.summ[SUM_MEAS] = |(i_meas_event & q.meas_mask);
      d.summ[SUM_QUES] = |(i_ques_event & q.ques_mask);
      if (accept) begin
         unique case (i_cmd_op)
            CMD_WR_STD: begin
               if (i_cmd_data <= STD_MAX) begin
                  d.std_mask = i_cmd_data[7:0];
               end
            end
            CMD_WR_OPER: begin
               if (i_cmd_data <= REG16_MAX) begin
                  d.oper_mask = i_cmd_data[15:0];
               end
            end
            CMD_WR_MEAS: begin
               if (i_cmd_data <= REG16_MAX) begin
                  d.meas_mask = i_cmd_data[15:0];
               end
            end
            CMD_WR_QUES: begin
               if (i_cmd_data <= REG16_MAX) begin
                  d.ques_mask = i_cmd_data[15:0];
               end
            end
            CMD_RD_STD: begin
               oq.push  = 1'b1;
               oq.wdata = {24'h00_0000, q.std_mask};
            end
            CMD_RD_OPER: begin
               oq.push  = 1'b1;
               oq.wdata = {16'h0000, q.oper_mask};
            end
            CMD_RD_MEAS: begin
               oq.push  = 1'b1;
               oq.wdata = {16'h0000, q.meas_mask};
            end
            CMD_RD_QUES: begin
               oq.push  = 1'b1;
               oq.wdata = {16'h0000, q.ques_mask};
            end
            CMD_QUE_READ: begin
               oq.push = 1'b1;
               if (eq.empty) begin
                  oq.wdata = {8'h00, CODE_NOERR, TEXT_NOERR};
               end else begin
                  oq.wdata = {8'h00, eq.rdata};
                  eq.pop   = 1'b1;
               end
            end
            CMD_QUE_CLEAR, CMD_CLS: begin
               eq.clear = 1'b1;
            end
            CMD_PRESET: begin
               d.std_mask  = STD_MASK_RST;
               d.oper_mask = REG16_RST;
               d.meas_mask = REG16_RST;
               d.ques_mask = REG16_RST;
            end
            CMD_QEN_START: begin
               d.base_err   = 1'b0;
               d.base_sta   = 1'b0;
               d.list       = '0;
               d.list_cnt   = '0;
               d.list_allow = 1'b1;
            end
            CMD_QDIS_START: begin
               d.list_allow = 1'b0;
            end
            CMD_QLIST_ITEM: begin
               if (q.list_cnt < LCW'(LIST_DEPTH)) begin
                  d.list[q.list_cnt].valid = 1'b1;
                  d.list[q.list_cnt].allow = q.list_allow;
                  d.list[q.list_cnt].lo    = (code_a < code_b) ? code_a : code_b;
                  d.list[q.list_cnt].hi    = (code_a < code_b) ? code_b : code_a;
                  d.list_cnt               = LCW'(q.list_cnt + 1'b1);
               end
            end
            default: begin
            end
         endcase
      end
      err_cnt_eff = eq.clear ? '0 : eq.count;
      if (i_msg_valid && admits(q, i_msg_code, i_msg_is_status)
          && (err_cnt_eff < ECW'(ERR_DEPTH))) begin
         eq.push = 1'b1;
         if (err_cnt_eff == ECW'(ERR_DEPTH - 1)) begin
            eq.wdata = {CODE_OVF, TEXT_OVF};
         end else begin
            eq.wdata = {i_msg_code, i_msg_text};
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         q          <= '0;
         q.base_err <= BASE_ERR_RST;
         q.base_sta <= BASE_STA_RST;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      o_status_byte              = 8'h00;
      o_status_byte[STB_MAV_BIT] = !oq.empty;
      o_status_byte[STB_EAV_BIT] = !eq.empty;
      o_talk_valid               = !oq.empty;
      o_talk_data                = oq.rdata;
      o_event_summary            = q.summ;
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   property p_std_write;
      accept && (i_cmd_op == CMD_WR_STD) && (i_cmd_data <= STD_MAX)
      |=> q.std_mask == $past(i_cmd_data[7:0]);
   endproperty
   a_std_write: assert property (p_std_write) else $error("Standard mask not stored.");

   property p_preset_clears;
      accept && (i_cmd_op == CMD_PRESET)
      |=> (q.std_mask == 8'h00) && (q.oper_mask == 16'h0000) && (q.meas_mask == 16'h0000)
          && (q.ques_mask == 16'h0000);
   endproperty
   a_preset_clears: assert property (p_preset_clears) else $error("Preset left a mask set.");

   property p_cls_keeps;
      accept && (i_cmd_op == CMD_CLS)
      |=> $stable(q.std_mask) && $stable(q.oper_mask) && $stable(q.list);
   endproperty
   a_cls_keeps: assert property (p_cls_keeps) else $error("Clear-status changed setup.");

   property p_query_enqueues;
      accept && (i_cmd_op == CMD_RD_MEAS) && !oq.pop
      |=> (oq.count == $past(oq.count) + 1'b1) ##0 o_status_byte[STB_MAV_BIT];
   endproperty
   a_query_enqueues: assert property (p_query_enqueues) else $error("Query not queued.");

   property p_noerr_read;
      accept && (i_cmd_op == CMD_QUE_READ) && eq.empty
      |-> oq.push && (oq.wdata == {8'h00, CODE_NOERR, TEXT_NOERR});
   endproperty
   a_noerr_read: assert property (p_noerr_read) else $error("Empty read not code 0.");

   property p_ovf_last;
      eq.push && (err_cnt_eff == ECW'(ERR_DEPTH - 1)) |-> eq.wdata[23:8] == CODE_OVF;
   endproperty
   a_ovf_last: assert property (p_ovf_last) else $error("Overflow entry missing.");

   property p_eav_clear;
      (eq.count == 1) && eq.pop && !eq.push |=> !o_status_byte[STB_EAV_BIT];
   endproperty
   a_eav_clear: assert property (p_eav_clear) else $error("Error flag stuck.");

   property p_summary;
      1'b1 |=> o_event_summary[SUM_OPER] == $past(|(i_oper_event & q.oper_mask));
   endproperty
   a_summary: assert property (p_summary) else $error("Operation summary wrong.");

   property p_oper_write;
      accept && (i_cmd_op == CMD_WR_OPER) && (i_cmd_data <= REG16_MAX)
      |=> q.oper_mask == $past(i_cmd_data[15:0]);
   endproperty
   a_oper_write: assert property (p_oper_write) else $error("Oper mask not stored.");

   property p_ques_write;
      accept && (i_cmd_op == CMD_WR_QUES) && (i_cmd_data <= REG16_MAX)
      |=> q.ques_mask == $past(i_cmd_data[15:0]);
   endproperty
   a_ques_write: assert property (p_ques_write) else $error("Ques mask not stored.");

   property p_std_refuse;
      accept && (i_cmd_op == CMD_WR_STD) && (i_cmd_data > STD_MAX)
      |=> $stable(q.std_mask);
   endproperty
   a_std_refuse: assert property (p_std_refuse) else $error("Wide write changed mask.");

   property p_mav_set;
      oq.push && !oq.full
      |=> o_status_byte[STB_MAV_BIT];
   endproperty
   a_mav_set: assert property (p_mav_set) else $error("Message flag not set.");

   property p_mav_clear;
      (oq.count == 1) && oq.pop && !oq.push
      |=> !o_status_byte[STB_MAV_BIT];
   endproperty
   a_mav_clear: assert property (p_mav_clear) else $error("Message flag stuck.");

   property p_eav_set;
      eq.push && !eq.full
      |=> o_status_byte[STB_EAV_BIT];
   endproperty
   a_eav_set: assert property (p_eav_set) else $error("Error flag not set.");

   property p_full_drops;
      eq.full && !eq.clear
      |-> !eq.push;
   endproperty
   a_full_drops: assert property (p_full_drops) else $error("Full queue took entry.");

endmodule : smq_top
`default_nettype wire

// >>> bench/smq_ctrl_model.sv
// Behavioural remote controller that sends commands and reads talk words.
`timescale 1ns/100ps
`default_nettype none
module smq_ctrl_model
   import smq_pkg::*;
(
   input  wire logic         i_core_clk,
   input  wire logic         i_cmd_ready,
   input  wire logic         i_talk_valid,
   input  wire logic [31:0]  i_talk_data,
   output smq_pkg::smq_cmd_t o_cmd_op,
   output logic              o_cmd_valid,
   output logic [31:0]       o_cmd_data,
   output logic              o_talk_rd
);
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_op    = CMD_CLS;
      o_cmd_data  = 32'h0000_0000;
      o_talk_rd   = 1'b0;
   end

   // Holds the command until it is taken or 64 further cycles pass, then drops it.
   task automatic cmd(input smq_cmd_t op, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_op    <= op;
      o_cmd_data  <= d;
      @(posedge i_core_clk);
      while (!i_cmd_ready && n < 64) begin
         @(posedge i_core_clk);
         n++;
      end
      o_cmd_valid <= 1'b0;
      o_cmd_data  <= ~d;
   endtask : cmd

   // Addresses the device to talk and takes the head word.
   task automatic talk(output logic [31:0] d, output logic v);
      @(negedge i_core_clk);
      v = i_talk_valid;
      d = i_talk_data;
      @(posedge i_core_clk);
      o_talk_rd <= 1'b1;
      @(posedge i_core_clk);
      o_talk_rd <= 1'b0;
   endtask : talk
endmodule : smq_ctrl_model
`default_nettype wire

// >>> bench/test_status_enable_and_message_queues.sv
// Self-checking testbench for the status enable and message queue block.
`timescale 1ns/100ps
`default_nettype none
module test_status_enable_and_message_queues;
   import smq_pkg::*;
   logic              i_core_clk, i_rst, cmd_valid, cmd_ready, talk_rd, talk_valid;
   smq_cmd_t          cmd_op;
   logic [31:0]       cmd_data, talk_data;
   logic              i_msg_valid, i_msg_is_status;
   logic signed [15:0] i_msg_code;
   logic [7:0]        i_msg_text, i_std_event, o_status_byte;
   logic [15:0]       i_oper_event, i_meas_event, i_ques_event;
   logic [3:0]        o_event_summary;
   int                miscompares = 0;
   int                compares    = 0;
   smq_cmd_t          wop [4] = '{CMD_WR_STD, CMD_WR_OPER, CMD_WR_MEAS, CMD_WR_QUES};
   smq_cmd_t          rop [4] = '{CMD_RD_STD, CMD_RD_OPER, CMD_RD_MEAS, CMD_RD_QUES};
   logic [31:0]       lim [4] = '{32'h0000_00FF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF};

   smq_top smq_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
      .i_cmd_op(cmd_op), .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready), .i_talk_rd(talk_rd),
      .o_talk_valid(talk_valid), .o_talk_data(talk_data), .i_msg_valid(i_msg_valid),
      .i_msg_code(i_msg_code), .i_msg_text(i_msg_text), .i_msg_is_status(i_msg_is_status),
      .i_std_event(i_std_event), .i_oper_event(i_oper_event), .i_meas_event(i_meas_event),
      .i_ques_event(i_ques_event), .o_event_summary(o_event_summary),
      .o_status_byte(o_status_byte));

   smq_ctrl_model smq_ctrl_model_inst (.i_core_clk(i_core_clk), .i_cmd_ready(cmd_ready),
      .i_talk_valid(talk_valid), .i_talk_data(talk_data), .o_cmd_op(cmd_op),
      .o_cmd_valid(cmd_valid), .o_cmd_data(cmd_data), .o_talk_rd(talk_rd));

   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   task automatic cmd(input smq_cmd_t op, input logic [31:0] d);
      smq_ctrl_model_inst.cmd(op, d);
   endtask : cmd

   task automatic rdq(input smq_cmd_t op, input logic [31:0] exp);
      logic [31:0] d;
      logic        v;
      cmd(op, 32'h0000_0000);
      smq_ctrl_model_inst.talk(d, v);
      chk({31'h0, v}, 32'h0000_0001, "talk word present");
      chk(d, exp, "talk word");
   endtask : rdq

   task automatic msg(input logic signed [15:0] c, input logic s);
      @(posedge i_core_clk);
      i_msg_valid     <= 1'b1;
      i_msg_code      <= c;
      i_msg_text      <= c[7:0];
      i_msg_is_status <= s;
      @(posedge i_core_clk);
      i_msg_valid     <= 1'b0;
      i_msg_code      <= ~c;
   endtask : msg

   task automatic stb(input logic [7:0] e);
      @(negedge i_core_clk);
      chk({24'h0, o_status_byte}, {24'h0, e}, "status byte");
   endtask : stb

   task automatic ev(input logic [7:0] s, input logic [15:0] o, input logic [15:0] m,
                     input logic [15:0] q, input logic [3:0] e);
      @(posedge i_core_clk);
      i_std_event  <= s;
      i_oper_event <= o;
      i_meas_event <= m;
      i_ques_event <= q;
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk({28'h0, o_event_summary}, {28'h0, e}, "event summary");
   endtask : ev

   function automatic logic [31:0] ew(input logic signed [15:0] c);
      return {8'h00, c, c[7:0]};
   endfunction : ew

   task automatic item(input logic [15:0] lo, input logic [15:0] hi);
      cmd(CMD_QLIST_ITEM, {hi, lo});
   endtask : item

   initial begin
      #100000;
      miscompares++;
      end_sim();
   end

   initial begin
      i_rst = 1'b1;
      {i_msg_valid, i_msg_is_status, i_msg_code, i_msg_text} = '0;
      {i_std_event, i_oper_event, i_meas_event, i_ques_event} = '0;
      repeat (3) @(posedge i_core_clk);
      i_rst <= 1'b0;
      stb(8'h00);
      for (int i = 0; i < 4; i++) begin
         rdq(rop[i], 32'h0000_0000);
         cmd(wop[i], lim[i]);
         rdq(rop[i], lim[i]);
         cmd(wop[i], lim[i] + 32'h0000_0001);
         rdq(rop[i], lim[i]);
         cmd(wop[i], 32'h0000_0000);
         rdq(rop[i], 32'h0000_0000);
      end
      $display("test masks done");
      cmd(CMD_WR_STD, 32'h0000_000F);
      cmd(CMD_WR_OPER, 32'h0000_0100);
      cmd(CMD_WR_MEAS, 32'h0000_0200);
      cmd(CMD_WR_QUES, 32'h0000_4000);
      ev(8'hF0, 16'hFEFF, 16'hFDFF, 16'hBFFF, 4'h0);
      ev(8'h01, 16'h0100, 16'h0000, 16'h0000, 4'h3);
      ev(8'hFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 4'hF);
      cmd(CMD_CLS, 32'h0000_0000);
      ev(8'hFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 4'hF);
      cmd(CMD_PRESET, 32'h0000_0000);
      ev(8'hFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 4'h0);
      $display("test summary done");
      cmd(CMD_WR_STD, 32'h0000_005A);
      cmd(CMD_WR_OPER, 32'h0000_1234);
      cmd(CMD_RD_STD, 32'h0000_0000);
      cmd(CMD_RD_OPER, 32'h0000_0000);
      stb(8'h10);
      begin
         logic [31:0] d;
         logic        v;
         smq_ctrl_model_inst.talk(d, v);
         chk(d, 32'h0000_005A, "first response");
         smq_ctrl_model_inst.talk(d, v);
         chk(d, 32'h0000_1234, "second response");
      end
      stb(8'h00);
      for (int i = 0; i < OUT_DEPTH; i++) cmd(CMD_RD_STD, 32'h0000_0000);
      stb(8'h10);
      chk({31'h0, cmd_ready}, 32'h0000_0000, "ready with full queue");
      begin
         logic [31:0] d;
         logic        v;
         for (int i = 0; i < OUT_DEPTH; i++) begin
            smq_ctrl_model_inst.talk(d, v);
            chk(d, 32'h0000_005A, "queued response");
         end
      end
      stb(8'h00);
      chk({31'h0, cmd_ready}, 32'h0000_0001, "ready after drain");
      $display("test output queue done");
      rdq(CMD_QUE_READ, ew(16'h0000));
      msg(16'h0014, 1'b1);
      stb(8'h00);
      msg(16'hFF92, 1'b0);
      msg(16'h0204, 1'b0);
      stb(8'h04);
      rdq(CMD_QUE_READ, ew(16'hFF92));
      rdq(CMD_QUE_READ, ew(16'h0204));
      stb(8'h00);
      for (int i = 1; i <= 12; i++) msg(16'(i), 1'b0);
      for (int i = 1; i <= 9; i++) rdq(CMD_QUE_READ, ew(16'(i)));
      rdq(CMD_QUE_READ, {8'h00, CODE_OVF, TEXT_OVF});
      rdq(CMD_QUE_READ, ew(16'h0000));
      $display("test error queue done");
      cmd(CMD_QEN_START, 32'h0000_0000);
      item(16'hFF92, 16'hFF22);
      item(16'hFED4, 16'hFED4);
      msg(16'hFF6A, 1'b0);
      msg(16'hFE70, 1'b0);
      msg(16'h0005, 1'b0);
      rdq(CMD_QUE_READ, ew(16'hFF6A));
      rdq(CMD_QUE_READ, ew(16'h0000));
      msg(16'hFED4, 1'b0);
      cmd(CMD_CLS, 32'h0000_0000);
      stb(8'h00);
      msg(16'hFF88, 1'b0);
      msg(16'h0005, 1'b0);
      cmd(CMD_QDIS_START, 32'h0000_0000);
      item(16'hFF6A, 16'hFF6A);
      msg(16'hFF6A, 1'b0);
      msg(16'hFF7E, 1'b0);
      cmd(CMD_PRESET, 32'h0000_0000);
      msg(16'h0005, 1'b0);
      rdq(CMD_QUE_READ, ew(16'hFF88));
      rdq(CMD_QUE_READ, ew(16'hFF7E));
      rdq(CMD_QUE_READ, ew(16'h0000));
      msg(16'hFF88, 1'b0);
      cmd(CMD_QUE_CLEAR, 32'h0000_0000);
      stb(8'h00);
      cmd(CMD_QEN_START, 32'h0000_0000);
      msg(16'hFF88, 1'b0);
      stb(8'h00);
      $display("test enable list done");
      end_sim();
   end
endmodule : test_status_enable_and_message_queues
`default_nettype wire
